/* verilog/pc_stack_pkg.sv */
// Purpose: shared constants and types for the program counter and return stack
// Assumes: 12-bit register address, 8-bit register data
// Notes: core registers decode on the low seven address bits only

package pc_stack_pkg;

   // ***********************************
   // widths and sizes
   // ***********************************
   localparam int PC_W = 15;
   localparam int STACK_DEPTH = 16;
   localparam int IDX_W = 5;
   localparam int ADDR_W = 12;

   // ***********************************
   // register offsets
   // ***********************************
   localparam logic [6:0] OFS_PC_LOW_BYTE = 7'h02;
   localparam logic [6:0] OFS_PC_HIGH_LATCH = 7'h0a;
   localparam logic [6:0] CORE_SPAN = 7'h0c;
   localparam logic [11:0] OFS_EVENT_STATUS = 12'hfe0;
   localparam logic [11:0] OFS_EVENT_MASK = 12'hfe1;
   localparam logic [11:0] OFS_STATUS_SHADOW = 12'hfe4;
   localparam logic [11:0] OFS_WORKING_SHADOW = 12'hfe5;
   localparam logic [11:0] OFS_BANK_SELECT_SHADOW = 12'hfe6;
   localparam logic [11:0] OFS_PC_HIGH_LATCH_SHADOW = 12'hfe7;
   localparam logic [11:0] OFS_POINTER0_LOW_SHADOW = 12'hfe8;
   localparam logic [11:0] OFS_POINTER0_HIGH_SHADOW = 12'hfe9;
   localparam logic [11:0] OFS_POINTER1_LOW_SHADOW = 12'hfea;
   localparam logic [11:0] OFS_POINTER1_HIGH_SHADOW = 12'hfeb;
   localparam logic [11:0] OFS_STACK_INDEX = 12'hfed;
   localparam logic [11:0] OFS_STACK_TOP_LOW = 12'hfee;
   localparam logic [11:0] OFS_STACK_TOP_HIGH = 12'hfef;

   // ***********************************
   // field positions and reset values
   // ***********************************
   localparam int EVT_OVERFLOW = 0;
   localparam int EVT_UNDERFLOW = 1;
   localparam logic [4:0] IDX_EMPTY = 5'h1f;
   localparam logic [4:0] IDX_TOP = 5'h0f;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [14:0] INT_VECTOR = 15'h0004;
   localparam logic [7:0] WORKING_SHADOW_RESET = 8'h00;

   // ***********************************
   // types
   // ***********************************
   typedef enum logic [3:0] {
      OP_HOLD,
      OP_STEP,
      OP_LOAD_PC_LOW,
      OP_CALL,
      OP_CALL_INDIRECT,
      OP_BRANCH_WORKING,
      OP_BRANCH_RELATIVE,
      OP_RETURN,
      OP_RETURN_LITERAL,
      OP_RETURN_INTERRUPT,
      OP_INTERRUPT
   } pc_op_t;

   typedef struct packed {
      pc_op_t op;
      logic [10:0] operand;
      logic [7:0] result;
   } pc_req_t;

   typedef struct packed {
      logic [2:0] status;
      logic [7:0] working;
      logic [4:0] bank;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
   } core_ctx_t;

   typedef struct packed {
      logic [2:0] status;
      logic [7:0] working;
      logic [4:0] bank;
      logic [6:0] pc_high_latch;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
   } shadow_t;

endpackage : pc_stack_pkg

/* verilog/pc_stack_core.sv */
// Purpose: program counter sequencing and 16-level hardware return stack
// Assumes: one operation request per clock from the decoder, bus inputs synchronous
// Notes: a stack fault with fault reset enabled clears pc and index, flags survive
//
// What this block does
// RULE1 - program counter is fifteen bits, covering all program memory
// RULE2 - program counter clears to zero on every reset
// RULE3 - pc low byte readable and writable; upper bits only via high latch
// RULE4 - writing pc low byte also loads upper seven bits from high latch
// RULE5 - call loads low byte and bits 2..0 from operand, 6..3 from latch
// RULE6 - indirect call loads low byte from working, upper from latch
// RULE7 - branch by working loads pc plus one plus unsigned working
// RULE8 - relative branch loads pc plus one plus sign-extended operand
// RULE9 - separate return stack of sixteen fifteen-bit entries
// RULE10 - calls, indirect calls and interrupt entry push return address
// RULE11 - return, literal return and interrupt return pop into pc
// RULE12 - pushes and pops never touch the high latch, except interrupt return, which reloads it from its shadow
// RULE13 - fault reset disabled: stack wraps, seventeenth push overwrites first
// RULE14 - overflow and underflow flags set whether fault reset enabled or not
// RULE15 - core registers decode identically in every bank
// RULE16 - five-bit stack index, all ones empty, points at occupied slot
// RULE17 - push increments index then writes; pop reads then decrements
// RULE18 - fault reset enabled: push past sixteen or pop past one resets
// RULE19 - interrupt entry saves context to shadows; interrupt return restores

`timescale 1ns/1ps

module pc_stack_core
   import pc_stack_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire pc_req_t req_in,
   input wire core_ctx_t ctx_in,
   input wire logic stack_fault_reset_enable_in,
   output logic [PC_W-1:0] pc_out,
   output logic [6:0] pc_high_latch_out,
   output shadow_t shadow_out,
   output logic restore_out,
   output logic fault_reset_out,
   output logic irq_out
);

   // ***********************************
   // state
   // ***********************************
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [6:0] pc_high_latch;
      logic [IDX_W-1:0] idx;
      logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
      shadow_t shad;
      logic [1:0] evt;
      logic [1:0] mask;
      logic irq;
      logic [7:0] rdata;
      logic restore;
      logic fault;
   } state_t;

   localparam state_t STATE_RESET = '{
      pc: PC_RESET,
      pc_high_latch: 7'h00,
      idx: IDX_EMPTY,
      stk: '0,
      shad: '{status: 3'h0, working: WORKING_SHADOW_RESET, bank: 5'h00,
              pc_high_latch: 7'h00, ptr0: 16'h0000, ptr1: 16'h0000},
      evt: 2'h0,
      mask: 2'h0,
      irq: 1'b0,
      rdata: 8'h00,
      restore: 1'b0,
      fault: 1'b0
   };

   state_t q;
   state_t d;

   // ***********************************
   // decode
   // ***********************************
   logic core_hit;
   logic [14:0] pc_plus1;
   logic [14:0] ret_addr;
   logic do_push;
   logic do_pop;
   logic ovf_ev;
   logic unf_ev;
   logic [1:0] w1c;
   logic [IDX_W-1:0] push_idx;

   // RULE15 bank-independent decode
   assign core_hit = addr_in[6:0] < CORE_SPAN;
   assign pc_plus1 = q.pc + 15'h0001;

   // RULE10 push sources
   assign do_push = req_in.op inside {OP_CALL, OP_CALL_INDIRECT, OP_INTERRUPT};
   // RULE11 pop sources
   assign do_pop = req_in.op inside {OP_RETURN, OP_RETURN_LITERAL,
                                     OP_RETURN_INTERRUPT};
   // interrupt resumes the instruction it displaced, calls resume after themselves
   assign ret_addr = (req_in.op == OP_INTERRUPT) ? q.pc : pc_plus1;

   // RULE14 flags raised regardless of fault reset enable
   assign ovf_ev = do_push && (q.idx == IDX_TOP);
   assign unf_ev = do_pop && (q.idx == IDX_EMPTY);
   // RULE17 index moves before the write
   assign push_idx = q.idx + 5'h01;

   assign w1c = (wr_in && addr_in == OFS_EVENT_STATUS) ? wdata_in[1:0] : 2'h0;

   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      d = q;
      d.restore = 1'b0;
      d.fault = 1'b0;
      d.rdata = 8'h00;

      // read answers from state before this cycle's writes
      if (rd_in) begin
         if (core_hit) begin
            case (addr_in[6:0])
               // RULE3 low byte readable
               OFS_PC_LOW_BYTE: d.rdata = q.pc[7:0];
               OFS_PC_HIGH_LATCH: d.rdata = {1'b0, q.pc_high_latch};
               default: d.rdata = 8'h00;
            endcase
         end else begin
            case (addr_in)
               OFS_EVENT_STATUS: d.rdata = {6'h00, q.evt};
               OFS_EVENT_MASK: d.rdata = {6'h00, q.mask};
               OFS_STATUS_SHADOW: d.rdata = {5'h00, q.shad.status};
               OFS_WORKING_SHADOW: d.rdata = q.shad.working;
               OFS_BANK_SELECT_SHADOW: d.rdata = {3'h0, q.shad.bank};
               OFS_PC_HIGH_LATCH_SHADOW: d.rdata = {1'b0, q.shad.pc_high_latch};
               OFS_POINTER0_LOW_SHADOW: d.rdata = q.shad.ptr0[7:0];
               OFS_POINTER0_HIGH_SHADOW: d.rdata = q.shad.ptr0[15:8];
               OFS_POINTER1_LOW_SHADOW: d.rdata = q.shad.ptr1[7:0];
               OFS_POINTER1_HIGH_SHADOW: d.rdata = q.shad.ptr1[15:8];
               OFS_STACK_INDEX: d.rdata = {3'h0, q.idx};
               OFS_STACK_TOP_LOW: d.rdata = q.stk[q.idx[3:0]][7:0];
               OFS_STACK_TOP_HIGH: d.rdata = {1'b0, q.stk[q.idx[3:0]][14:8]};
               default: d.rdata = 8'h00;
            endcase
         end
      end

      // software writes; a core operation in the same cycle overrides them
      if (wr_in) begin
         if (core_hit) begin
            case (addr_in[6:0])
               // RULE4 low byte write loads all fifteen bits
               OFS_PC_LOW_BYTE: d.pc = {q.pc_high_latch, wdata_in};
               OFS_PC_HIGH_LATCH: d.pc_high_latch = wdata_in[6:0];
               default: d.pc = d.pc;
            endcase
         end else begin
            case (addr_in)
               OFS_EVENT_MASK: d.mask = wdata_in[1:0];
               OFS_STATUS_SHADOW: d.shad.status = wdata_in[2:0];
               OFS_WORKING_SHADOW: d.shad.working = wdata_in;
               OFS_BANK_SELECT_SHADOW: d.shad.bank = wdata_in[4:0];
               OFS_PC_HIGH_LATCH_SHADOW: d.shad.pc_high_latch = wdata_in[6:0];
               OFS_POINTER0_LOW_SHADOW: d.shad.ptr0[7:0] = wdata_in;
               OFS_POINTER0_HIGH_SHADOW: d.shad.ptr0[15:8] = wdata_in;
               OFS_POINTER1_LOW_SHADOW: d.shad.ptr1[7:0] = wdata_in;
               OFS_POINTER1_HIGH_SHADOW: d.shad.ptr1[15:8] = wdata_in;
               OFS_STACK_INDEX: d.idx = wdata_in[4:0];
               OFS_STACK_TOP_LOW: d.stk[q.idx[3:0]][7:0] = wdata_in;
               OFS_STACK_TOP_HIGH: d.stk[q.idx[3:0]][14:8] = wdata_in[6:0];
               default: d.mask = d.mask;
            endcase
         end
      end

      // core operations
      case (req_in.op)
         OP_HOLD: d.pc = d.pc;
         OP_STEP: d.pc = pc_plus1;
         // RULE4 instruction result into low byte
         OP_LOAD_PC_LOW: d.pc = {q.pc_high_latch, req_in.result};
         // RULE5 absolute call target
         OP_CALL: d.pc = {q.pc_high_latch[6:3], req_in.operand};
         // RULE6 indirect call target
         OP_CALL_INDIRECT: d.pc = {q.pc_high_latch, ctx_in.working};
         // RULE7 unsigned working offset, may cross a 256-word block
         OP_BRANCH_WORKING: d.pc = pc_plus1 + {7'h00, ctx_in.working};
         // RULE8 signed nine-bit operand
         OP_BRANCH_RELATIVE:
            d.pc = pc_plus1 + {{6{req_in.operand[8]}}, req_in.operand[8:0]};
         OP_INTERRUPT: d.pc = INT_VECTOR;
         default: d.pc = d.pc;
      endcase

      // RULE9 RULE16 stack push with index step first
      // RULE12 high latch is left alone by push and pop, except interrupt return, which restores it below
      if (do_push) begin
         if (ovf_ev && stack_fault_reset_enable_in) begin
            d.fault = 1'b1;
         end else begin
            // RULE13 wrap from the top slot back to the first
            d.idx = ovf_ev ? 5'h00 : push_idx;
            d.stk[d.idx[3:0]] = ret_addr;
         end
      end

      // RULE17 pop reads out then steps the index down
      if (do_pop) begin
         if (unf_ev && stack_fault_reset_enable_in) begin
            d.fault = 1'b1;
         end else begin
            d.pc = q.stk[q.idx[3:0]];
            d.idx = q.idx - 5'h01;
         end
      end

      // RULE19 context save on entry, restore on interrupt return
      if (req_in.op == OP_INTERRUPT) begin
         d.shad.status = ctx_in.status;
         d.shad.working = ctx_in.working;
         d.shad.bank = ctx_in.bank;
         d.shad.pc_high_latch = q.pc_high_latch;
         d.shad.ptr0 = ctx_in.ptr0;
         d.shad.ptr1 = ctx_in.ptr1;
      end
      if (req_in.op == OP_RETURN_INTERRUPT && !d.fault) begin
         d.pc_high_latch = q.shad.pc_high_latch;
         d.restore = 1'b1;
      end

      // RULE18 fault reset clears pc and index like any reset
      if (d.fault) begin
         d.pc = PC_RESET;
         d.idx = IDX_EMPTY;
      end

      // RULE14 sticky flags, a new event wins over a clear
      d.evt = (q.evt & ~w1c) | {unf_ev, ovf_ev};
      d.irq = |(d.evt & d.mask);
   end

   // ***********************************
   // registers
   // ***********************************
   // RULE2 synchronous clear of pc
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         q <= STATE_RESET;
      end else begin
         q <= d;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   // RULE1 full fifteen-bit pc out
   assign pc_out = q.pc;
   assign pc_high_latch_out = q.pc_high_latch;
   assign shadow_out = q.shad;
   assign restore_out = q.restore;
   assign fault_reset_out = q.fault;
   assign irq_out = q.irq;
   assign rdata_out = q.rdata;

endmodule : pc_stack_core

/* bench/pc_stack_core_asserts.sv */
// Purpose: port-level checks on the program counter and return stack
// Assumes: one clock domain, synchronous reset
// Notes: stack index is not a port, so stack order is seen through pc

`timescale 1ns/1ps

module pc_stack_core_asserts
   import pc_stack_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire pc_req_t req_in,
   input wire core_ctx_t ctx_in,
   input wire logic stack_fault_reset_enable_in,
   input wire logic [7:0] rdata_out,
   input wire logic [PC_W-1:0] pc_out,
   input wire logic [6:0] pc_high_latch_out,
   input wire shadow_t shadow_out,
   input wire logic restore_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   wire pc_op_t op = req_in.op;
   // fault reset would clear pc, so push and pop targets are checked in wrap mode only
   wire wrap = !stack_fault_reset_enable_in;
   // ****
   // checks
   // ****
   pc_clear_a:
      assert property (disable iff (1'b0) reset_in |=> pc_out == PC_RESET)
      else $error("pc not cleared by reset");
   low_load_a:
      assert property (op == OP_LOAD_PC_LOW
         |=> pc_out == {$past(pc_high_latch_out), $past(req_in.result)})
      else $error("pc low byte load wrong");
   call_target_a:
      assert property (op == OP_CALL && wrap
         |=> pc_out == {$past(pc_high_latch_out[6:3]), $past(req_in.operand)})
      else $error("call target wrong");
   indirect_call_a:
      assert property (op == OP_CALL_INDIRECT && wrap
         |=> pc_out == {$past(pc_high_latch_out), $past(ctx_in.working)})
      else $error("indirect call target wrong");
   working_branch_a:
      assert property (op == OP_BRANCH_WORKING
         |=> pc_out == $past(pc_out) + 15'h1 + {7'h00, $past(ctx_in.working)})
      else $error("working branch target wrong");
   rel_branch_a:
      assert property (op == OP_BRANCH_RELATIVE |=> pc_out == $past(pc_out) + 15'h1
         + {{6{$past(req_in.operand[8])}}, $past(req_in.operand[8:0])})
      else $error("relative branch target wrong");
   call_return_a:
      assert property ((op == OP_CALL && wrap) ##1 op == OP_RETURN
         |=> pc_out == $past(pc_out, 2) + 15'h1)
      else $error("return address wrong");
   latch_hold_a:
      assert property (!wr_in && op inside {OP_CALL, OP_CALL_INDIRECT, OP_INTERRUPT,
         OP_RETURN, OP_RETURN_LITERAL} |=> $stable(pc_high_latch_out))
      else $error("latch moved on push or pop");
   int_vector_a:
      assert property (op == OP_INTERRUPT && wrap |=> pc_out == INT_VECTOR)
      else $error("interrupt vector wrong");
   shadow_save_a:
      assert property (op == OP_INTERRUPT && wrap |=> shadow_out.working ==
         $past(ctx_in.working) && shadow_out.pc_high_latch == $past(pc_high_latch_out))
      else $error("shadow capture wrong");
   restore_a:
      assert property (op == OP_RETURN_INTERRUPT && wrap |=> restore_out)
      else $error("restore pulse missing");
   read_quiet_a:
      assert property (rdata_out != 8'h00 |-> $past(rd_in))
      else $error("read data outside read slot");
   call_ret_c: cover property (op == OP_CALL ##1 op == OP_RETURN);
   restore_c: cover property (restore_out);
   read_c: cover property (rdata_out != 8'h00);
endmodule : pc_stack_core_asserts

/* bench/core_side_model.sv */
// Purpose: core context holder standing for the decoder and interrupt logic
// Assumes: restore pulse lasts one cycle
// Notes: restore wins over a software context update in the same cycle

`timescale 1ns/1ps

module core_side_model
   import pc_stack_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire core_ctx_t ctx_cmd_in,
   input wire logic ctx_we_in,
   input wire logic restore_in,
   input wire shadow_t shadow_in,
   output core_ctx_t ctx_out
);
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         ctx_out <= '0;
      end else if (restore_in) begin
         ctx_out <= '{shadow_in.status, shadow_in.working, shadow_in.bank,
            shadow_in.ptr0, shadow_in.ptr1};
      end else if (ctx_we_in) begin
         ctx_out <= ctx_cmd_in;
      end
   end
endmodule : core_side_model

/* bench/pc_stack_core_test.sv */
// Purpose: self-checking bench for the program counter and return stack
// Assumes: expectations queued by drivers, checked on the falling edge
// Notes: stack contents mirrored in a small array, same wrap as hardware

`timescale 1ns/1ps

module pc_stack_core_test;
   import pc_stack_pkg::*;
   logic mclk_in, reset_in, wr, rd, fen, ctx_we, want, irq, restore, fault;
   logic seen_pc = 1'b0, seen_rd = 1'b0;
   pc_req_t req;
   core_ctx_t ctx_cmd, ctx;
   shadow_t shadow;
   logic [11:0] addr;
   logic [7:0] wdata, rdata, w, q_rd[$];
   logic [6:0] lat, hl;
   logic [14:0] pc, pcm, stk[16], q_pc[$];
   logic [4:0] idx;
   logic [10:0] o;
   logic [8:0] r;
   int failures = 0, n_compared = 0;

   pc_stack_core i_pc_stack_core (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .req_in(req),
      .ctx_in(ctx), .stack_fault_reset_enable_in(fen), .pc_out(pc),
      .pc_high_latch_out(hl), .shadow_out(shadow), .restore_out(restore),
      .fault_reset_out(fault), .irq_out(irq));
   core_side_model i_core_side_model (.mclk_in(mclk_in), .reset_in(reset_in),
      .ctx_cmd_in(ctx_cmd), .ctx_we_in(ctx_we), .restore_in(restore),
      .shadow_in(shadow), .ctx_out(ctx));

   // ****
   // drivers and monitor
   // ****
   task check(input logic [14:0] seen, input logic [14:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task drv(input pc_op_t k, input logic [10:0] opd, input logic [7:0] res,
      input logic wv, input logic rv, input logic [11:0] a, input logic [7:0] d,
      input logic c);
      req <= '{k, opd, res};
      wr <= wv;
      rd <= rv;
      addr <= a;
      wdata <= d;
      want <= c;
      ctx_we <= 1'b0;
      @(posedge mclk_in);
   endtask : drv
   task idle;
      drv(OP_HOLD, 11'h000, 8'h00, 1'b0, 1'b0, 12'h000, 8'h00, 1'b0);
   endtask : idle
   task rd8(input logic [11:0] a, input logic [7:0] e);
      q_rd.push_back(e);
      drv(OP_HOLD, 11'h000, 8'h00, 1'b0, 1'b1, a, 8'h00, 1'b0);
   endtask : rd8
   task wr8(input logic [11:0] a, input logic [7:0] d);
      drv(OP_HOLD, 11'h000, 8'h00, 1'b1, 1'b0, a, d, 1'b0);
   endtask : wr8
   task op(input pc_op_t k, input logic [10:0] opd, input logic [7:0] res,
      input logic [14:0] e);
      q_pc.push_back(e);
      pcm = e;
      drv(k, opd, res, 1'b0, 1'b0, 12'h000, 8'h00, 1'b1);
   endtask : op
   task push(input logic [14:0] v);
      idx = (idx == IDX_TOP) ? 5'h00 : idx + 5'h01;
      stk[idx[3:0]] = v;
   endtask : push
   task pop(input pc_op_t k);
      logic [14:0] e;
      e = stk[idx[3:0]];
      idx = idx - 5'h01;
      op(k, 11'h000, 8'h00, e);
   endtask : pop
   task setw(input logic [7:0] v);
      // park the core op and bus so the earlier request is not repeated
      req <= '{OP_HOLD, 11'h000, 8'h00};
      wr <= 1'b0;
      rd <= 1'b0;
      want <= 1'b0;
      ctx_cmd.working <= v;
      ctx_we <= 1'b1;
      @(posedge mclk_in);
   endtask : setw
   task irq_is(input logic e);
      idle();
      idle();
      @(negedge mclk_in);
      check({14'h0000, irq}, {14'h0000, e});
      @(posedge mclk_in);
   endtask : irq_is
   task rst(input int n);
      reset_in <= 1'b1;
      repeat (n) idle();
      reset_in <= 1'b0;
      idx = IDX_EMPTY;
      pcm = PC_RESET;
      lat = 7'h00;
   endtask : rst
   task close_out;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   always @(posedge mclk_in) begin
      seen_pc <= want;
      seen_rd <= rd;
   end
   always @(negedge mclk_in) begin
      if (seen_pc) check(pc, q_pc.pop_front());
      if (seen_rd) check({7'h00, rdata}, {7'h00, q_rd.pop_front()});
   end

   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   // a hang costs at most a few thousand cycles
   initial begin
      repeat (3000) @(posedge mclk_in);
      failures++;
      close_out();
   end

   // ****
   // scenarios
   // ****
   initial begin
      void'($urandom(52));
      {wr, rd, fen, ctx_we, want, addr, wdata} = '0;
      req = '{OP_HOLD, 11'h000, 8'h00};
      ctx_cmd = '0;
      reset_in = 1'b1;
      rst(8);
      op(OP_HOLD, 11'h000, 8'h00, PC_RESET);
      rd8(OFS_STACK_INDEX, {3'h0, IDX_EMPTY});
      rd8(OFS_WORKING_SHADOW, WORKING_SHADOW_RESET);
      rd8(12'hfec, 8'h00);
      lat = 7'h15;
      wr8(12'h08a, {1'b0, lat});
      op(OP_LOAD_PC_LOW, 11'h000, 8'h34, {lat, 8'h34});
      rd8(12'h402, 8'h34);
      op(OP_STEP, 11'h000, 8'h00, pcm + 15'h1);
      for (int i = 0; i < 4; i++) begin
         o = 11'($urandom);
         w = 8'($urandom);
         r = 9'($urandom);
         push(pcm + 15'h1);
         op(OP_CALL, o, 8'h00, {lat[6:3], o});
         rd8(OFS_STACK_INDEX, 8'h00);
         rd8(OFS_STACK_TOP_LOW, stk[0][7:0]);
         rd8(OFS_STACK_TOP_HIGH, {1'b0, stk[0][14:8]});
         pop(OP_RETURN);
         setw(w);
         op(OP_BRANCH_WORKING, 11'h000, 8'h00, pcm + 15'h1 + {7'h00, w});
         op(OP_BRANCH_RELATIVE, {2'b00, r}, 8'h00, pcm + 15'h1 + {{6{r[8]}}, r});
         push(pcm + 15'h1);
         op(OP_CALL_INDIRECT, 11'h000, 8'h00, {lat, w});
         pop(OP_RETURN_LITERAL);
      end
      for (int i = 0; i < 17; i++) begin
         push(pcm + 15'h1);
         op(OP_CALL, 11'(i), 8'h00, {lat[6:3], 11'(i)});
      end
      rd8(OFS_EVENT_STATUS, 8'h01);
      pop(OP_RETURN);
      pop(OP_RETURN);
      rd8(OFS_EVENT_STATUS, 8'h03);
      wr8(OFS_EVENT_MASK, 8'h02);
      irq_is(1'b1);
      wr8(OFS_EVENT_STATUS, 8'h02);
      irq_is(1'b0);
      rd8(OFS_EVENT_STATUS, 8'h01);
      rst(2);
      fen <= 1'b1;
      op(OP_LOAD_PC_LOW, 11'h000, 8'h9c, {lat, 8'h9c});
      op(OP_RETURN, 11'h000, 8'h00, PC_RESET);
      #1 check({14'h0000, fault}, 15'h0001);
      rd8(OFS_STACK_INDEX, {3'h0, IDX_EMPTY});
      rd8(OFS_EVENT_STATUS, 8'h02);
      fen <= 1'b0;
      lat = 7'h15;
      wr8(12'h00a, {1'b0, lat});
      setw(8'h5a);
      push(pcm);
      op(OP_INTERRUPT, 11'h000, 8'h00, INT_VECTOR);
      rd8(OFS_WORKING_SHADOW, 8'h5a);
      rd8(OFS_PC_HIGH_LATCH_SHADOW, {1'b0, lat});
      setw(8'h11);
      wr8(12'h00a, 8'h07);
      pop(OP_RETURN_INTERRUPT);
      idle();
      op(OP_LOAD_PC_LOW, 11'h000, 8'h66, {lat, 8'h66});
      op(OP_BRANCH_WORKING, 11'h000, 8'h00, pcm + 15'h5b);
      push(pcm + 15'h1);
      op(OP_CALL, 11'h2a5, 8'h00, {lat[6:3], 11'h2a5});
      pop(OP_RETURN);
      idle();
      idle();
      close_out();
   end
endmodule : pc_stack_core_test

bind pc_stack_core pc_stack_core_asserts i_pc_stack_core_asserts (.mclk_in(mclk_in),
   .reset_in(reset_in), .rd_in(rd_in), .wr_in(wr_in), .req_in(req_in), .ctx_in(ctx_in),
   .stack_fault_reset_enable_in(stack_fault_reset_enable_in), .rdata_out(rdata_out),
   .pc_out(pc_out), .pc_high_latch_out(pc_high_latch_out), .shadow_out(shadow_out),
   .restore_out(restore_out));
